/* File: mraf_params.svh */
`ifndef MRAF_PARAMS_SVH
`define MRAF_PARAMS_SVH

`define MRAF_OFS_BUS    8'h05
`define MRAF_OFS_TEMP   8'h06
`define MRAF_OFS_CUR    8'h07
`define MRAF_OFS_PWR    8'h08
`define MRAF_OFS_DIAG   8'h0b

`define MRAF_B_LATCH    15
`define MRAF_B_RDYEN    14
`define MRAF_B_AVGCMP   13
`define MRAF_B_POLSEL   12
`define MRAF_B_OVF      9
`define MRAF_B_LIM_HI   7
`define MRAF_B_LIM_LO   2
`define MRAF_B_CONV     1
`define MRAF_B_TRIM     0

`define MRAF_RES_RST    16'h0000
`define MRAF_PWR_RST    24'h000000
`define MRAF_TEMP_RST   12'h000
`define MRAF_CTL_RST    4'h0
`define MRAF_LIM_RST    6'h00
`define MRAF_AVG_ONE    3'h0
`define MRAF_PWR_SHIFT  8

`endif

/* File: mraf_pkg.sv */
`default_nettype none
package mraf_pkg;

   typedef enum logic [1:0] {
      MRAF_LNK_IDLE = 2'b01,
      MRAF_LNK_WAIT = 2'b10
   } mraf_lnk_state_t;

   typedef logic [23:0] mraf_rdata_t;
   typedef logic [7:0]  mraf_addr_t;
   typedef logic [15:0] mraf_word_t;

endpackage
`default_nettype wire

/* File: mraf_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mraf_params.svh"

module mraf_top
   import mraf_pkg::*;
(
   // Core clock, reset and enable.
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        ce_i,
   // Register access from the serial engine, on the link clock.
   input  wire logic        lnk_clk_i,
   input  wire logic        lnk_req_i,
   input  wire logic        lnk_wr_i,
   input  wire logic [7:0]  lnk_addr_i,
   input  wire logic [15:0] lnk_wdata_i,
   output logic             lnk_busy_o,
   output logic             lnk_done_o,
   output logic [23:0]      lnk_rdata_o,
   // Measurement stream from the converter and arithmetic.
   input  wire logic        smp_vld_i,
   input  wire logic        avg_done_i,
   input  wire logic [2:0]  averaging_count_i,
   input  wire logic [15:0] bus_voltage_i,
   input  wire logic [15:0] shunt_voltage_i,
   input  wire logic [11:0] die_temperature_i,
   input  wire logic [15:0] current_i,
   input  wire logic [23:0] power_i,
   // Conversion events.
   input  wire logic        conv_start_i,
   input  wire logic        conv_trig_i,
   input  wire logic        conv_done_i,
   input  wire logic        math_ovf_i,
   input  wire logic        chksum_err_i,
   // Limit thresholds.
   input  wire logic [15:0] shunt_over_lim_i,
   input  wire logic [15:0] shunt_under_lim_i,
   input  wire logic [14:0] bus_over_lim_i,
   input  wire logic [14:0] bus_under_lim_i,
   input  wire logic [11:0] temperature_limit_field_i,
   input  wire logic [15:0] power_lim_i,
   // Open-drain alert pin.
   output logic             alert_o,
   output logic             alert_oe_o
);

   // Reset release in both domains.
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic lrst_meta_ff;
   logic lrst_sync_ff;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   always_ff @(posedge lnk_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lrst_meta_ff <= 1'b0;
         lrst_sync_ff <= 1'b0;
      end else begin
         lrst_meta_ff <= 1'b1;
         lrst_sync_ff <= lrst_meta_ff;
      end
   end

   // Link domain: enable copy, request capture and answer return.
   logic            lce_s1_ff;
   logic            lce_s2_ff;
   logic            lce_s3_ff;
   logic            lce_ff;
   mraf_lnk_state_t lnk_state_ff;
   logic            req_tgl_ff;
   logic            hold_wr_ff;
   mraf_addr_t      hold_addr_ff;
   mraf_word_t      hold_wdata_ff;
   logic            ack_s1_ff;
   logic            ack_s2_ff;
   logic            ack_s3_ff;
   logic            ack_acc_ff;
   logic            ack_evt;
   logic            lnk_done_ff;
   mraf_rdata_t     lnk_rdata_ff;

   // Core-side answer, read by the link only after the toggle has crossed.
   logic            ack_tgl_ff;
   mraf_rdata_t     core_rdata_ff;

   always_ff @(posedge lnk_clk_i or negedge lrst_sync_ff) begin
      if (!lrst_sync_ff) begin
         lce_s1_ff <= 1'b0;
         lce_s2_ff <= 1'b0;
         lce_s3_ff <= 1'b0;
         lce_ff    <= 1'b0;
      end else begin
         lce_s1_ff <= ce_i;
         lce_s2_ff <= lce_s1_ff;
         lce_s3_ff <= lce_s2_ff;
         if (lce_s2_ff == lce_s3_ff) begin
            lce_ff <= lce_s3_ff;
         end
      end
   end

   always_ff @(posedge lnk_clk_i or negedge lrst_sync_ff) begin
      if (!lrst_sync_ff) begin
         ack_s1_ff  <= 1'b0;
         ack_s2_ff  <= 1'b0;
         ack_s3_ff  <= 1'b0;
         ack_acc_ff <= 1'b0;
      end else begin
         ack_s1_ff <= ack_tgl_ff;
         ack_s2_ff <= ack_s1_ff;
         ack_s3_ff <= ack_s2_ff;
         if (lce_ff && ack_s2_ff == ack_s3_ff) begin
            ack_acc_ff <= ack_s3_ff;
         end
      end
   end

   assign ack_evt = lce_ff && (ack_s2_ff == ack_s3_ff) && (ack_s3_ff != ack_acc_ff);

   // The held request stays still until the answer returns, so the core
   // may sample it several cycles after the toggle without tearing.
   always_ff @(posedge lnk_clk_i or negedge lrst_sync_ff) begin
      if (!lrst_sync_ff) begin
         lnk_state_ff  <= MRAF_LNK_IDLE;
         req_tgl_ff    <= 1'b0;
         hold_wr_ff    <= 1'b0;
         hold_addr_ff  <= 8'h00;
         hold_wdata_ff <= 16'h0000;
         lnk_done_ff   <= 1'b0;
         lnk_rdata_ff  <= 24'h000000;
      end else if (lce_ff) begin
         lnk_done_ff <= 1'b0;
         case (lnk_state_ff)
            MRAF_LNK_IDLE: begin
               if (lnk_req_i) begin
                  hold_wr_ff    <= lnk_wr_i;
                  hold_addr_ff  <= lnk_addr_i;
                  hold_wdata_ff <= lnk_wdata_i;
                  req_tgl_ff    <= ~req_tgl_ff;
                  lnk_state_ff  <= MRAF_LNK_WAIT;
               end
            end
            MRAF_LNK_WAIT: begin
               if (ack_evt) begin
                  lnk_rdata_ff <= core_rdata_ff;
                  lnk_done_ff  <= 1'b1;
                  lnk_state_ff <= MRAF_LNK_IDLE;
               end
            end
            default: begin
               lnk_state_ff <= MRAF_LNK_IDLE;
            end
         endcase
      end
   end

   assign lnk_busy_o  = (lnk_state_ff != MRAF_LNK_IDLE);
   assign lnk_done_o  = lnk_done_ff;
   assign lnk_rdata_o = lnk_rdata_ff;

   // Core domain: request toggle arrival.
   logic req_s1_ff;
   logic req_s2_ff;
   logic req_s3_ff;
   logic req_acc_ff;
   logic req_evt;

   always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         req_s1_ff  <= 1'b0;
         req_s2_ff  <= 1'b0;
         req_s3_ff  <= 1'b0;
         req_acc_ff <= 1'b0;
      end else if (ce_i) begin
         req_s1_ff <= req_tgl_ff;
         req_s2_ff <= req_s1_ff;
         req_s3_ff <= req_s2_ff;
         if (req_s2_ff == req_s3_ff) begin
            req_acc_ff <= req_s3_ff;
         end
      end
   end

   assign req_evt = ce_i && (req_s2_ff == req_s3_ff) && (req_s3_ff != req_acc_ff);

   // Control bits and flags.
   logic [3:0]  ctl_ff;
   logic [5:0]  lim_ff;
   logic [5:0]  nxt_lim;
   logic        conv_ff;
   logic        ovf_ff;
   logic        trim_ff;
   logic        latch_select;
   logic        ready_on_alert_enable;
   logic        averaged_compare_select;
   logic        output_polarity_select;
   logic        cmp_stb;
   logic        res_stb;
   logic        rd_clr;
   logic        trig_start;
   logic [5:0]  lim_cond;
   logic        alert_act;
   logic        alert_oe_ff;

   assign latch_select            = ctl_ff[3];
   assign ready_on_alert_enable   = ctl_ff[2];
   assign averaged_compare_select = ctl_ff[1];
   assign output_polarity_select  = ctl_ff[0];

   assign cmp_stb    = averaged_compare_select ? avg_done_i : smp_vld_i;
   assign res_stb    = avg_done_i ||
                       (smp_vld_i && averaging_count_i == `MRAF_AVG_ONE);
   assign trig_start = conv_start_i && conv_trig_i;
   assign rd_clr     = req_evt && !hold_wr_ff && hold_addr_ff == `MRAF_OFS_DIAG &&
                       latch_select;

   // Limit conditions, ordered as the flag field from bit 7 down to bit 2.
   assign lim_cond[5] = $signed(die_temperature_i) >
                        $signed(temperature_limit_field_i);
   assign lim_cond[4] = $signed(shunt_voltage_i) > $signed(shunt_over_lim_i);
   assign lim_cond[3] = $signed(shunt_voltage_i) < $signed(shunt_under_lim_i);
   assign lim_cond[2] = bus_voltage_i > {1'b0, bus_over_lim_i};
   assign lim_cond[1] = bus_voltage_i < {1'b0, bus_under_lim_i};
   assign lim_cond[0] = power_i > {power_lim_i, 8'h00};

   // In latched mode a new violation in the clearing cycle survives.
   always_comb begin
      if (latch_select) begin
         nxt_lim = (rd_clr ? `MRAF_LIM_RST : lim_ff) |
                   (cmp_stb ? lim_cond : `MRAF_LIM_RST);
      end else begin
         nxt_lim = cmp_stb ? lim_cond : lim_ff;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         lim_ff <= `MRAF_LIM_RST;
      end else if (ce_i) begin
         lim_ff <= nxt_lim;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         conv_ff <= 1'b0;
      end else if (ce_i) begin
         if (conv_done_i) begin
            conv_ff <= 1'b1;
         end else if (latch_select ? (rd_clr || trig_start) : conv_start_i) begin
            conv_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         ovf_ff <= 1'b0;
      end else if (ce_i) begin
         if (math_ovf_i) begin
            ovf_ff <= 1'b1;
         end else if (trig_start) begin
            ovf_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         trim_ff <= 1'b1;
      end else if (ce_i && chksum_err_i) begin
         trim_ff <= 1'b0;
      end
   end

   // Only the four control bits take writes; flags and reserved bits do not.
   always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         ctl_ff <= `MRAF_CTL_RST;
      end else if (req_evt && hold_wr_ff && hold_addr_ff == `MRAF_OFS_DIAG) begin
         ctl_ff <= hold_wdata_ff[`MRAF_B_LATCH:`MRAF_B_POLSEL];
      end
   end

   // Result registers.
   mraf_word_t  bus_ff;
   logic [11:0] temp_ff;
   mraf_word_t  cur_ff;
   mraf_rdata_t pwr_ff;

   always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         bus_ff  <= `MRAF_RES_RST;
         temp_ff <= `MRAF_TEMP_RST;
         cur_ff  <= `MRAF_RES_RST;
         pwr_ff  <= `MRAF_PWR_RST;
      end else if (ce_i && res_stb) begin
         // A negative bus reading can only be noise, so it is held at zero.
         bus_ff  <= bus_voltage_i[15] ? `MRAF_RES_RST : bus_voltage_i;
         temp_ff <= die_temperature_i;
         cur_ff  <= current_i;
         pwr_ff  <= power_i;
      end
   end

   // Register read decode.
   function automatic mraf_word_t diag_word(input logic [3:0] ctl,
                                            input logic       ovf,
                                            input logic [5:0] lim,
                                            input logic       conv,
                                            input logic       trim);
      diag_word = {ctl, 2'b00, ovf, 1'b0, lim, conv, trim};
   endfunction

   function automatic mraf_rdata_t read_mux(input mraf_addr_t a);
      case (a)
         `MRAF_OFS_BUS:  read_mux = {8'h00, bus_ff};
         `MRAF_OFS_TEMP: read_mux = {8'h00, temp_ff, 4'h0};
         `MRAF_OFS_CUR:  read_mux = {8'h00, cur_ff};
         `MRAF_OFS_PWR:  read_mux = pwr_ff;
         `MRAF_OFS_DIAG: read_mux = {8'h00, diag_word(ctl_ff, ovf_ff, lim_ff, conv_ff, trim_ff)};
         default:        read_mux = 24'h000000;
      endcase
   endfunction

   // The read samples the flags in the same edge that clears them.
   always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         core_rdata_ff <= 24'h000000;
         ack_tgl_ff    <= 1'b0;
      end else if (req_evt) begin
         if (!hold_wr_ff) begin
            core_rdata_ff <= read_mux(hold_addr_ff);
         end
         ack_tgl_ff <= ~ack_tgl_ff;
      end
   end

   // Alert pin. The pin can only pull low, so the active-high sense is
   // produced by releasing it while active.
   assign alert_act = (|lim_ff) || (ready_on_alert_enable && conv_ff);

   always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         alert_oe_ff <= 1'b0;
      end else if (ce_i) begin
         alert_oe_ff <= output_polarity_select ? !alert_act : alert_act;
      end
   end

   assign alert_o    = 1'b0;
   assign alert_oe_o = alert_oe_ff;

endmodule
`default_nettype wire

/* File: mraf_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module mraf_asserts (
   input wire logic        ref_clk_i,
   input wire logic        rst_b_i,
   input wire logic        lnk_clk_i,
   input wire logic        lnk_req_i,
   input wire logic        lnk_busy_o,
   input wire logic        lnk_done_o,
   input wire logic [23:0] lnk_rdata_o,
   input wire logic        smp_vld_i,
   input wire logic        avg_done_i,
   input wire logic        conv_done_i,
   input wire logic        conv_start_i,
   input wire logic        math_ovf_i,
   input wire logic        alert_o,
   input wire logic        alert_oe_o
);
   logic [3:0] quiet_ff;
   // Busy covers the whole register access, so a control write shows up as activity here.
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) quiet_ff <= 4'h0;
      else if (smp_vld_i | avg_done_i | conv_done_i | conv_start_i | math_ovf_i | lnk_busy_o)
         quiet_ff <= 4'h0;
      else if (quiet_ff != 4'hf) quiet_ff <= quiet_ff + 4'h1;
   end
   sequence s_take;
      lnk_req_i && !lnk_busy_o;
   endsequence
   sequence s_answer;
      lnk_done_o && !lnk_busy_o;
   endsequence
   a_take_busy: assert property (@(posedge lnk_clk_i) disable iff (!rst_b_i)
      s_take |=> lnk_busy_o) else $error("request not taken");
   a_busy_answer: assert property (@(posedge lnk_clk_i) disable iff (!rst_b_i)
      s_take |-> ##[2:30] s_answer) else $error("access never answered");
   a_done_pulse: assert property (@(posedge lnk_clk_i) disable iff (!rst_b_i)
      lnk_done_o |=> !lnk_done_o) else $error("done longer than one cycle");
   a_busy_fall: assert property (@(posedge lnk_clk_i) disable iff (!rst_b_i)
      $fell(lnk_busy_o) |-> lnk_done_o) else $error("busy dropped without done");
   a_rdata_hold: assert property (@(posedge lnk_clk_i) disable iff (!rst_b_i)
      $changed(lnk_rdata_o) |-> lnk_done_o) else $error("read data moved between answers");
   a_alert_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      !alert_o) else $error("alert data not low");
   a_oe_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      $changed(alert_oe_o) |-> quiet_ff < 4'h8) else $error("alert moved without cause");
   a_oe_steady: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      quiet_ff == 4'hf |-> $stable(alert_oe_o)) else $error("alert moved while quiet");
endmodule
bind mraf_top mraf_asserts chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
   .lnk_clk_i(lnk_clk_i), .lnk_req_i(lnk_req_i), .lnk_busy_o(lnk_busy_o),
   .lnk_done_o(lnk_done_o), .lnk_rdata_o(lnk_rdata_o), .smp_vld_i(smp_vld_i),
   .avg_done_i(avg_done_i), .conv_done_i(conv_done_i), .conv_start_i(conv_start_i),
   .math_ovf_i(math_ovf_i), .alert_o(alert_o), .alert_oe_o(alert_oe_o));
`default_nettype wire

/* File: mraf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mraf_host_model (
   input  wire logic        lnk_clk_i,
   input  wire logic        lnk_busy_o,
   input  wire logic        lnk_done_o,
   input  wire logic [23:0] lnk_rdata_o,
   output var  logic        lnk_req_o,
   output var  logic        lnk_wr_o,
   output var  logic [7:0]  lnk_addr_o,
   output var  logic [15:0] lnk_wdata_o
);
   initial begin
      {lnk_req_o, lnk_wr_o, lnk_addr_o, lnk_wdata_o} = 26'h0000000;
   end
   // A lost answer returns unknown data so that the caller's compare fails.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       output logic [23:0] q);
      int n;
      n = 0;
      @(negedge lnk_clk_i);
      while (lnk_busy_o)
         @(negedge lnk_clk_i);
      {lnk_req_o, lnk_wr_o, lnk_addr_o, lnk_wdata_o} = {1'b1, wr, a, d};
      @(negedge lnk_clk_i);
      // The request is only taken while the link side sees the enable, so hold it until busy.
      while (!lnk_busy_o && n < 40) begin
         @(negedge lnk_clk_i);
         n++;
      end
      lnk_req_o = 1'b0;
      n = 0;
      while (!lnk_done_o && n < 40) begin
         @(negedge lnk_clk_i);
         n++;
      end
      q = lnk_done_o ? lnk_rdata_o : 24'hxxxxxx;
      @(negedge lnk_clk_i);
      lnk_addr_o = ~a;
      lnk_wdata_o = ~d;
   endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import mraf_pkg::*;
   localparam logic [5:0] SMP = 6'h20, AVERAGING_COUNT = 6'h10, CDN = 6'h08;
   localparam logic [5:0] CST = 6'h04, OVF = 6'h02, CHK = 6'h01;
   logic        ref_clk_i, lnk_clk_i, rst_b_i, conv_trig_i, lnk_req_i, lnk_wr_i, ce_i;
   logic        lnk_busy_o, lnk_done_o, alert_o, alert_oe_o;
   logic [5:0]  evt;
   logic [2:0]  averaging_count_i;
   mraf_addr_t  lnk_addr_i;
   mraf_word_t  lnk_wdata_i, bus_voltage_i, shunt_voltage_i, current_i, power_lim_i;
   mraf_word_t  shunt_over_lim_i, shunt_under_lim_i;
   logic [14:0] bus_over_lim_i, bus_under_lim_i;
   logic [11:0] die_temperature_i, temperature_limit_field_i;
   mraf_rdata_t lnk_rdata_o, power_i, got;
   int          miscompares, n_compared;
   mraf_top uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
      .lnk_clk_i(lnk_clk_i), .lnk_req_i(lnk_req_i), .lnk_wr_i(lnk_wr_i),
      .lnk_addr_i(lnk_addr_i), .lnk_wdata_i(lnk_wdata_i), .lnk_busy_o(lnk_busy_o),
      .lnk_done_o(lnk_done_o), .lnk_rdata_o(lnk_rdata_o), .smp_vld_i(evt[5]),
      .avg_done_i(evt[4]), .averaging_count_i(averaging_count_i),
      .bus_voltage_i(bus_voltage_i), .shunt_voltage_i(shunt_voltage_i),
      .die_temperature_i(die_temperature_i), .current_i(current_i), .power_i(power_i),
      .conv_start_i(evt[2]), .conv_trig_i(conv_trig_i), .conv_done_i(evt[3]),
      .math_ovf_i(evt[1]), .chksum_err_i(evt[0]), .shunt_over_lim_i(shunt_over_lim_i),
      .shunt_under_lim_i(shunt_under_lim_i), .bus_over_lim_i(bus_over_lim_i),
      .bus_under_lim_i(bus_under_lim_i), .power_lim_i(power_lim_i),
      .temperature_limit_field_i(temperature_limit_field_i),
      .alert_o(alert_o), .alert_oe_o(alert_oe_o));
   mraf_host_model host (.lnk_clk_i(lnk_clk_i), .lnk_busy_o(lnk_busy_o),
      .lnk_done_o(lnk_done_o), .lnk_rdata_o(lnk_rdata_o), .lnk_req_o(lnk_req_i),
      .lnk_wr_o(lnk_wr_i), .lnk_addr_o(lnk_addr_i), .lnk_wdata_o(lnk_wdata_i));
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      lnk_clk_i = 1'b0;
      #3.3;
      forever #7.5 lnk_clk_i = ~lnk_clk_i;
   end
   task automatic summarize;
      if (miscompares == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input mraf_rdata_t g, input mraf_rdata_t e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rd(input mraf_addr_t a, input mraf_rdata_t e);
      host.xfer(1'b0, a, 16'h0000, got);
      chk(got, e);
   endtask
   task automatic wr(input mraf_addr_t a, input mraf_word_t d);
      host.xfer(1'b1, a, d, got);
   endtask
   task automatic oe(input logic e);
      chk({23'h000000, alert_oe_o}, {23'h000000, e});
   endtask
   task automatic ev(input logic [5:0] m);
      @(negedge ref_clk_i);
      evt = m;
      @(negedge ref_clk_i);
      evt = 6'h00;
      repeat (3) @(negedge ref_clk_i);
   endtask
   // Every value sits clear of every limit, so each of the first six changes below trips exactly one flag; the seventh trips none.
   task automatic base;
      {bus_voltage_i, shunt_voltage_i, die_temperature_i} = {16'h0800, 16'h0000, 12'h100};
      {power_i, power_lim_i, temperature_limit_field_i} = {24'h000100, 16'h0002, 12'h200};
      {shunt_over_lim_i, shunt_under_lim_i} = {16'h0100, 16'hff00};
      {bus_over_lim_i, bus_under_lim_i} = {15'h1000, 15'h0400};
   endtask
   task automatic t_reset;
      for (int a = 5; a < 9; a++)
         rd(8'(a), 24'h000000);
      rd(8'h0b, 24'h000001);
      rd(8'h20, 24'h000000);
      oe(1'b0);
   endtask
   task automatic t_results;
      {bus_voltage_i, die_temperature_i, current_i} = {16'h1234, 12'habc, 16'h8001};
      power_i = 24'habcdef;
      ev(SMP);
      rd(8'h05, 24'h001234);
      rd(8'h06, 24'h00abc0);
      rd(8'h07, 24'h008001);
      rd(8'h08, 24'habcdef);
      bus_voltage_i = 16'h8000;
      averaging_count_i = 3'h2;
      ev(SMP);
      rd(8'h05, 24'h001234);
      ev(AVERAGING_COUNT);
      rd(8'h05, 24'h000000);
      averaging_count_i = 3'h0;
      wr(8'h07, 16'hffff);
      rd(8'h07, 24'h008001);
      // With the enable low a sample must neither load a result nor touch a flag.
      @(negedge ref_clk_i);
      ce_i = 1'b0;
      bus_voltage_i = 16'h0123;
      ev(SMP);
      ce_i = 1'b1;
      repeat (8) @(negedge lnk_clk_i);
      rd(8'h05, 24'h000000);
      rd(8'h0b, 24'h000015);
   endtask
   task automatic t_limits;
      for (int i = 0; i < 7; i++) begin
         base;
         case (i)
            0: temperature_limit_field_i = 12'h0ff;
            1: shunt_voltage_i = 16'h0101;
            2: shunt_voltage_i = 16'hfeff;
            3: bus_voltage_i = 16'h1001;
            4: bus_voltage_i = 16'h03ff;
            5: power_lim_i = 16'h0000;
            default: power_i = 24'h000200;
         endcase
         ev(SMP);
         rd(8'h0b, (i < 6) ? (24'h000080 >> i) | 24'h000001 : 24'h000001); // 17
         oe(i < 6);
         base;
         ev(SMP);
         rd(8'h0b, 24'h000001);
         oe(1'b0);
      end
   endtask
   task automatic t_ctl;
      wr(8'h0b, 16'hffff);
      rd(8'h0b, 24'h00f001);
      oe(1'b1);
      bus_voltage_i = 16'h1001;
      ev(SMP);
      rd(8'h0b, 24'h00f001);
      ev(AVERAGING_COUNT);
      oe(1'b0);
      rd(8'h0b, 24'h00f011);
      rd(8'h0b, 24'h00f001);
      oe(1'b1);
      base;
      ev(SMP);
   endtask
   task automatic t_latched;
      wr(8'h0b, 16'h8000);
      bus_voltage_i = 16'h1001;
      ev(SMP);
      base;
      ev(SMP);
      oe(1'b1);
      rd(8'h0b, 24'h008011);
      rd(8'h0b, 24'h008001);
      oe(1'b0);
      ev(CDN);
      rd(8'h0b, 24'h008003);
      rd(8'h0b, 24'h008001);
      ev(CDN | OVF);
      ev(CST);
      rd(8'h0b, 24'h008203);
      ev(CDN);
      conv_trig_i = 1'b1;
      ev(CST);
      conv_trig_i = 1'b0;
      rd(8'h0b, 24'h008001);
   endtask
   task automatic t_ready;
      wr(8'h0b, 16'h4000);
      ev(CDN);
      oe(1'b1);
      rd(8'h0b, 24'h004003);
      ev(CST);
      oe(1'b0);
      wr(8'h0b, 16'h0000);
      ev(CDN);
      oe(1'b0);
      ev(CHK);
      rd(8'h0b, 24'h000002);
   endtask
   initial begin
      {miscompares, n_compared, evt, conv_trig_i} = '0;
      ce_i = 1'b1;
      {averaging_count_i, current_i} = '0;
      base;
      rst_b_i = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      repeat (8) @(negedge lnk_clk_i);
      t_reset;
      t_results;
      t_limits;
      t_ctl;
      t_latched;
      t_ready;
      summarize;
   end
   initial begin
      #200000;
      miscompares++;
      $display("mismatch at %0t: run did not finish", $time);
      summarize;
   end
endmodule
`default_nettype wire
